/* rtl/wei_top.sv */
/*
  Wake event indication: power management control register, wake cause
  recording, external wake output and device ready sequencing.
  Assumes event strobes and source-pending levels come from logic on
  this clock, and that an AHB-Lite master owns the bus.
*/
`timescale 1ns/100ps
module wei_top #(
  parameter int PULSE_CYCLES = wei_pkg::WAKE_PULSE_CYCLES,
  parameter int SETTLE_COUNT = wei_pkg::SETTLE_CYCLES
) (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Wake detectors and sources
  input wire logic energy_evt_in,
  input wire logic wol_evt_in,
  input wire logic [1:0] src_pend_in,
  input wire logic soft_rst_in,
  // Wake pin and status
  output logic wake_event_out,
  output logic wake_event_oe_out,
  output logic wake_interrupt_out,
  output logic ready_out,
  output logic [1:0] power_state_out
);
  import wei_pkg::*;

  // ==========================================================
  // Declarations
  wei_bus_req_t req;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic [31:0] pmc_word;
  wei_pwr_t pwr_ff;
  wei_pwr_t nxt_pwr;
  logic [1:0] pstate_ff;
  logic [1:0] nxt_pstate;
  logic [1:0] status_ff;
  logic [1:0] nxt_status;
  logic [1:0] clr_mask;
  logic [1:0] new_cause;
  logic [1:0] cause_ff;
  logic energy_detect_enable_ff;
  logic lan_wake_enable_ff;
  logic type_ff;
  logic pol_ff;
  logic pulse_ff;
  logic oe_ff;
  logic active_ff;
  logic ready_ff;
  logic intr_ff;
  logic wr_pmc;
  logic bt_wr;
  logic ed_hit;
  logic wol_hit;
  logic any_hit;
  logic hold;
  logic drive;
  logic tmr_busy;
  logic settle_busy;
  logic sleep_req;
  logic wake_req;
  logic settle_done;
  logic nxt_out;
  logic nxt_oe;

  // ==========================================================
  // Bus front end
  wei_ahb_slave u_bus (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in[ADDR_W-1:0]),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hready_in(hready_in),
    .hwdata_in(hwdata_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .rd_data_in(rd_data),
    .req_out(req),
    .rd_addr_out(rd_addr)
  );

  // Write decode; only the byte test write acts while not ready
  assign wr_pmc = req.wr && ready_ff && req.addr == PMC_OFS;
  assign bt_wr = req.wr && req.addr == BYTE_TEST_OFS;

  // Control register image
  assign pmc_word = {18'h0, pstate_ff, 2'h0, lan_wake_enable_ff, energy_detect_enable_ff, 1'h0, type_ff,
                     status_ff, pulse_ff, pol_ff, oe_ff, ready_ff};

  // Read mux: control word always, config word always, any other offset reads zero
  assign rd_data = (rd_addr == PMC_OFS) ? pmc_word :
                   (rd_addr == HARDWARE_CONFIG_REGISTER_OFS) ? HARDWARE_CONFIG_REGISTER_VAL :
                   32'h0000_0000;

  // ==========================================================
  // Wake events and cause status
  assign ed_hit = energy_evt_in && energy_detect_enable_ff;
  assign wol_hit = wol_evt_in && lan_wake_enable_ff;
  assign any_hit = ed_hit || wol_hit;
  assign new_cause = wei_cause(ed_hit, wol_hit);

  // Write-one clear, gated by ready and by the sources feeding each bit
  assign clr_mask = (wr_pmc ? req.wdata[STAT_LO +: 2] : 2'h0) & ~src_pend_in;

  // A second, different cause ORs into the multiple code; set beats clear
  assign nxt_status = soft_rst_in ? STAT_NONE : (status_ff & ~clr_mask) | new_cause;

  // Cause status register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      status_ff <= STAT_NONE;
    else if (ce_in)
      status_ff <= nxt_status;
  end

  // ==========================================================
  // Configuration bits
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      energy_detect_enable_ff <= RST_BIT;
      lan_wake_enable_ff <= RST_BIT;
      pulse_ff <= RST_BIT;
      oe_ff <= RST_BIT;
    end
    else if (ce_in)
    begin
      if (soft_rst_in)
      begin
        energy_detect_enable_ff <= RST_BIT;
        lan_wake_enable_ff <= RST_BIT;
        pulse_ff <= RST_BIT;
        oe_ff <= RST_BIT;
      end
      else if (wr_pmc)
      begin
        energy_detect_enable_ff <= req.wdata[ENERGY_DETECT_ENABLE_BIT];
        lan_wake_enable_ff <= req.wdata[LAN_WAKE_ENABLE_BIT];
        pulse_ff <= req.wdata[PULSE_BIT];
        oe_ff <= req.wdata[OE_BIT];
      end
    end
  end

  // Polarity and drive type ignore soft reset
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pol_ff <= RST_BIT;
      type_ff <= RST_BIT;
    end
    else if (ce_in && wr_pmc)
    begin
      pol_ff <= req.wdata[POL_BIT];
      type_ff <= req.wdata[TYPE_BIT];
    end
  end

  // ==========================================================
  // Wake output generation
  // Output stays up only while a recorded cause still has its enable
  assign hold = status_ff != STAT_NONE && |(cause_ff & {lan_wake_enable_ff, energy_detect_enable_ff});

  // Pulse timer restarts on each enabled event in pulse mode
  wei_pulse_timer #(
    .CYCLES(PULSE_CYCLES),
    .BUSY_AT_RESET(1'b0)
  ) u_pulse (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .start_in(any_hit && pulse_ff),
    .stop_in(!hold && !any_hit),
    .busy_out(tmr_busy)
  );

  // Active level: fixed pulse or static hold
  assign drive = pulse_ff ? tmr_busy && hold : active_ff;

  // Static hold flag and recorded causes
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      active_ff <= 1'b0;
      cause_ff <= 2'h0;
      intr_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      // Only static mode latches, so a later switch out of pulse mode never leaves a stale level
      active_ff <= !pulse_ff && (any_hit || (active_ff && hold));
      cause_ff <= (nxt_status == STAT_NONE) ? 2'h0 : cause_ff | new_cause;
      intr_ff <= any_hit || (intr_ff && nxt_status != STAT_NONE);
    end
  end

  // Pin level: open-drain pulls low when active, push-pull follows polarity
  assign nxt_out = type_ff ? (drive ~^ pol_ff) : 1'b0;
  assign nxt_oe = oe_ff && (type_ff || drive);

  // Pin registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wake_event_out <= 1'b0;
      wake_event_oe_out <= 1'b0;
      wake_interrupt_out <= 1'b0;
    end
    else if (ce_in)
    begin
      wake_event_out <= nxt_out;
      wake_event_oe_out <= nxt_oe;
      wake_interrupt_out <= intr_ff;
    end
  end

  // ==========================================================
  // Power state and ready sequencing
  assign sleep_req = wr_pmc && req.wdata[PSTATE_LO +: 2] != PSTATE_D0 &&
                     req.wdata[PSTATE_LO +: 2] != PSTATE_RSVD;
  assign wake_req = bt_wr || any_hit;

  // Settle timer runs from power-up and after each wake
  wei_pulse_timer #(
    .CYCLES(SETTLE_COUNT),
    .BUSY_AT_RESET(1'b1)
  ) u_settle (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .start_in(pwr_ff == PS_ASLEEP && wake_req),
    .stop_in(1'b0),
    .busy_out(settle_busy)
  );
  assign settle_done = pwr_ff == PS_SETTLE && !settle_busy;

  // Next power state
  always_comb
  begin
    nxt_pwr = pwr_ff;
    nxt_pstate = pstate_ff;
    case (pwr_ff)
      PS_AWAKE:
        if (sleep_req)
        begin
          nxt_pwr = PS_ASLEEP;
          nxt_pstate = req.wdata[PSTATE_LO +: 2];
        end
      PS_ASLEEP:
        if (wake_req)
          nxt_pwr = PS_SETTLE;
      PS_SETTLE:
        if (settle_done)
        begin
          nxt_pwr = PS_AWAKE;
          nxt_pstate = PSTATE_D0;
        end
      default:
        nxt_pwr = PS_SETTLE;
    endcase
  end

  // Power state, mode field and ready flag
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pwr_ff <= PS_SETTLE;
      pstate_ff <= PSTATE_D0;
      ready_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      pwr_ff <= nxt_pwr;
      pstate_ff <= nxt_pstate;
      ready_ff <= nxt_pwr == PS_AWAKE;
    end
  end

  // Status outputs
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ready_out <= 1'b0;
      power_state_out <= PSTATE_D0;
    end
    else if (ce_in)
    begin
      ready_out <= ready_ff;
      power_state_out <= pstate_ff;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in || !ce_in);

  // Byte test write while asleep, then settling with ready low
  sequence s_settling;
    pwr_ff == PS_SETTLE && !ready_ff;
  endsequence
  sequence s_bt_wake;
    pwr_ff == PS_ASLEEP && bt_wr;
  endsequence

  chk_ready_settle: assert property ($rose(ready_ff) |-> $past(pwr_ff) == PS_SETTLE)
    else $error("ready rose without settling");
  chk_bt_wakes: assert property (s_bt_wake |=> s_settling)
    else $error("byte test write did not start settling");
  chk_clear_ready: assert property ($fell(status_ff[0]) && !$past(soft_rst_in) |-> $past(ready_ff))
    else $error("status cleared while not ready");
  chk_clear_src: assert property ($fell(status_ff[1]) && !$past(soft_rst_in) |-> !$past(src_pend_in[1]))
    else $error("status cleared with source pending");
  chk_multi_code: assert property (status_ff == STAT_ENERGY && wol_hit && clr_mask == 2'h0 && !soft_rst_in
                                   |=> status_ff == STAT_MULTI)
    else $error("second cause did not give multiple code");
  chk_pulse_end: assert property (pulse_ff && !tmr_busy && !any_hit |=> !drive)
    else $error("pulse output outlived timer");
  chk_static_hold: assert property (!pulse_ff && active_ff && hold |=> active_ff)
    else $error("static output dropped early");
  chk_deassert: assert property (status_ff == STAT_NONE && !any_hit |=> !active_ff)
    else $error("output stayed with status clear");
  chk_oe_gate: assert property (!oe_ff |=> !wake_event_oe_out)
    else $error("pin driven with enable clear");
  chk_od_low: assert property (!type_ff |=> !wake_event_out)
    else $error("open drain pin not low");
  chk_polarity: assert property (type_ff && oe_ff |=> wake_event_out == ($past(drive) ~^ $past(pol_ff)))
    else $error("pin level ignores polarity");
  chk_intr_indep: assert property (any_hit ##1 1'b1 |=> wake_interrupt_out)
    else $error("event did not raise interrupt");
  chk_rsvd_mode: assert property (pstate_ff != PSTATE_RSVD)
    else $error("reserved power state taken");
endmodule

/* rtl/wei_pkg.sv */
/*
  Constants, types and helpers shared by the wake event indication block.
  Assumes a 100 MHz clock and word-aligned AHB-Lite register access.
*/
// Contract
// - Two-bit field reports wake cause code
// - Writing one clears status bit, zero keeps
// - Status clears only while device ready
// - Status bit clears only after sources clear
// - Pulse mode drives fifty millisecond pulse
// - Static mode holds output until deactivated
// - Clearing status or enable drops output
// - Polarity bit sets level, survives soft reset
// - Open-drain ignores polarity, active low
// - Output driven only with enable bit set
// - Interrupt independent of output enable bit
// - Ready set only after settling completes
// - Control register readable in every state
// - Power state codes; reserved code refused
// - Byte test write wakes reduced state
// - Enabled event asserts output and interrupt
// - Drive type selects open-drain or push-pull
package wei_pkg;
  // ==========================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] PMC_OFS = 8'h00;
  localparam logic [7:0] BYTE_TEST_OFS = 8'h04;
  localparam logic [7:0] HARDWARE_CONFIG_REGISTER_OFS = 8'h08;
  // Arbitrary neutral value for the configuration word
  localparam logic [31:0] HARDWARE_CONFIG_REGISTER_VAL = 32'h0000_0000;
  // ==========================================================
  // Control register field positions
  localparam int READY_BIT = 0;
  localparam int OE_BIT = 1;
  localparam int POL_BIT = 2;
  localparam int PULSE_BIT = 3;
  localparam int STAT_LO = 4;
  localparam int TYPE_BIT = 6;
  localparam int ENERGY_DETECT_ENABLE_BIT = 8;
  localparam int LAN_WAKE_ENABLE_BIT = 9;
  localparam int PSTATE_LO = 12;
  // ==========================================================
  // Codes and reset values
  localparam logic [1:0] STAT_NONE = 2'h0;
  localparam logic [1:0] STAT_ENERGY = 2'h1;
  localparam logic [1:0] STAT_FRAME = 2'h2;
  localparam logic [1:0] STAT_MULTI = 2'h3;
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [1:0] PSTATE_RSVD = 2'h3;
  localparam logic RST_BIT = 1'h0;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_PULSE_MS = 50;
  localparam int WAKE_PULSE_CYCLES = WAKE_PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYCLES = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {PS_AWAKE = 2'b00, PS_ASLEEP = 2'b01, PS_SETTLE = 2'b10} wei_pwr_t;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } wei_bus_req_t;
  // Cause code from the two event strobes
  function automatic logic [1:0] wei_cause(input logic ed, input logic wol);
    wei_cause = {wol, ed};
  endfunction
endpackage

/* rtl/wei_pulse_timer.sv */
/*
  Down-counting one-shot timer: busy for CYCLES cycles after start.
  Assumes start and stop come from logic on the same clock.
*/
`timescale 1ns/100ps
module wei_pulse_timer #(
  parameter int CYCLES = 16,
  parameter bit BUSY_AT_RESET = 1'b0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Control
  input wire logic start_in,
  input wire logic stop_in,
  output logic busy_out
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Start reloads, stop aborts, otherwise count down to zero
  assign nxt_cnt = start_in ? LOAD : (stop_in || cnt_ff == '0) ? '0 : cnt_ff - W'(1);
  assign busy_out = cnt_ff != '0;

  // Counter state
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_ff <= BUSY_AT_RESET ? LOAD : '0;
    else if (ce_in)
      cnt_ff <= nxt_cnt;
  end
endmodule

/* rtl/wei_ahb_slave.sv */
/*
  AHB-Lite slave front end: zero-wait writes, one wait state on reads.
  Assumes single word transfers; the response is always OKAY.
*/
`timescale 1ns/100ps
module wei_ahb_slave (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Bus side
  input wire logic hsel_in,
  input wire logic [wei_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Register side
  input wire logic [31:0] rd_data_in,
  output wei_pkg::wei_bus_req_t req_out,
  output logic [wei_pkg::ADDR_W-1:0] rd_addr_out
);
  import wei_pkg::*;
  logic wr_pend_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic addr_phase;

  // Accepted address phase
  assign addr_phase = hsel_in && htrans_in[1] && hready_in;
  assign req_out = '{wr: wr_pend_ff, addr: addr_ff, wdata: hwdata_in};
  assign rd_addr_out = addr_ff;

  // Phase tracking, wait state and read data
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_pend_ff <= 1'b0;
      addr_ff <= '0;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
    else if (ce_in)
    begin
      wr_pend_ff <= addr_phase && hwrite_in;
      if (addr_phase)
        addr_ff <= haddr_in;
      hreadyout_out <= !(addr_phase && !hwrite_in);
      if (!hreadyout_out)
        hrdata_out <= rd_data_in;
      hresp_out <= 1'b0;
    end
  end
endmodule

/* tb/wei_host_wake_model.sv */
/*
  Far-side model of the system wake logic: pull-up on the wake wire and a
  counter of the cycles spent at the active level since the last clear.
  Assumes one clock shared with the block and a bench that sets the level.
*/
`timescale 1ns/100ps
module wei_host_wake_model (
  // Clock and control
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic act_lvl_in,
  // Wake wire from the device
  input wire logic pin_in,
  input wire logic pin_oe_in,
  // Observed wire
  output logic lvl_out,
  output logic [15:0] act_cnt_out
);
  // ==========================================================
  // Wire resolution
  // A released wire floats to the pull-up level, as in a wired-OR net
  assign lvl_out = pin_oe_in ? pin_in : 1'h1;
  // ==========================================================
  // Active level counter
  // Counts cycles at the active level so pulse widths can be judged
  always_ff @(posedge clk_in)
  begin
    if (clr_in)
      act_cnt_out <= 16'h0000;
    else if (lvl_out === act_lvl_in)
      act_cnt_out <= act_cnt_out + 16'h0001;
  end
endmodule

/* tb/wake_event_indication_tb_top.sv */
/*
  Self-checking bench for the wake event indication block: AHB-Lite host
  tasks, event strobes and one task per scenario.
  Assumes the design package and a far-side model on the wake wire.
*/
`timescale 1ns/100ps
module wake_event_indication_tb_top;
  import wei_pkg::*;
  // ==========================================================
  // Short counts for simulation and control bit masks
  localparam int PC = 20;
  localparam int SC = 30;
  localparam logic [31:0] M_RDY = 32'h1 << READY_BIT;
  localparam logic [31:0] M_OE = 32'h1 << OE_BIT;
  localparam logic [31:0] M_POL = 32'h1 << POL_BIT;
  localparam logic [31:0] M_PUL = 32'h1 << PULSE_BIT;
  localparam logic [31:0] M_PP = 32'h1 << TYPE_BIT;
  localparam logic [31:0] M_ED = 32'h1 << ENERGY_DETECT_ENABLE_BIT;
  localparam logic [31:0] M_WOL = 32'h1 << LAN_WAKE_ENABLE_BIT;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic energy = 1'h0;
  logic wol = 1'h0;
  logic soft_rst = 1'h0;
  logic [1:0] src_pend = 2'h0;
  logic clr = 1'h1;
  logic act_lvl = 1'h1;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin, pin_oe, intr, ready, lvl;
  logic [1:0] pstate;
  logic [15:0] act_cnt;
  int error_cnt = 0;
  int checks_done = 0;
  // Free-running 100 MHz clock
  always #5 clk_in = ~clk_in;
  // ==========================================================
  // Device and far side
  wei_top #(.PULSE_CYCLES(PC), .SETTLE_COUNT(SC)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'h1),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hready_in(hreadyout), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .energy_evt_in(energy), .wol_evt_in(wol), .src_pend_in(src_pend),
    .soft_rst_in(soft_rst), .wake_event_out(pin), .wake_event_oe_out(pin_oe), .wake_interrupt_out(intr),
    .ready_out(ready), .power_state_out(pstate));
  wei_host_wake_model far (.clk_in(clk_in), .clr_in(clr), .act_lvl_in(act_lvl), .pin_in(pin),
    .pin_oe_in(pin_oe), .lvl_out(lvl), .act_cnt_out(act_cnt));
  // ==========================================================
  // Shared tasks
  task summarize;
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One single transfer; address held until hready, then data until hready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (hreadyout !== 1'h1 && n < 40);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (hreadyout !== 1'h1 && n < 40);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
    if (n >= 40)
    begin
      error_cnt++;
      summarize();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task evt(input logic e, input logic w);
    @(posedge clk_in);
    energy <= e;
    wol <= w;
    @(posedge clk_in);
    energy <= 1'h0;
    wol <= 1'h0;
    cyc(4);
  endtask
  task soft_reset_bit;
    @(posedge clk_in);
    soft_rst <= 1'h1;
    @(posedge clk_in);
    soft_rst <= 1'h0;
    cyc(2);
  endtask
  // Host polls only the control register until ready is seen
  task wait_ready;
    int n;
    logic [31:0] q;
    n = 0;
    do
    begin
      bus(1'h0, PMC_OFS, 32'h0, q);
      n++;
    end
    while (q[READY_BIT] !== 1'h1 && n < 40);
    if (n >= 40)
    begin
      error_cnt++;
      summarize();
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_boot;
    wr(PMC_OFS, M_OE | M_ED);
    rchk(PMC_OFS, 32'h0);
    rchk(HARDWARE_CONFIG_REGISTER_OFS, HARDWARE_CONFIG_REGISTER_VAL);
    wait_ready();
    cyc(3);
    chk({31'h0, ready}, 32'h1);
    rchk(PMC_OFS, M_RDY);
    rchk(8'h10, 32'h0);
  endtask
  task t_codes;
    wr(PMC_OFS, M_ED | M_WOL);
    rchk(PMC_OFS, M_RDY | M_ED | M_WOL);
    evt(1'h1, 1'h0);
    chk({31'h0, intr}, 32'h1);
    chk({31'h0, pin_oe}, 32'h0);
    rchk(PMC_OFS, M_RDY | M_ED | M_WOL | 32'h10);
    evt(1'h0, 1'h1);
    rchk(PMC_OFS, M_RDY | M_ED | M_WOL | 32'h30);
    src_pend <= 2'h1;
    wr(PMC_OFS, M_ED | M_WOL | 32'h30);
    rchk(PMC_OFS, M_RDY | M_ED | M_WOL | 32'h10);
    src_pend <= 2'h0;
    wr(PMC_OFS, M_ED | M_WOL);
    rchk(PMC_OFS, M_RDY | M_ED | M_WOL | 32'h10);
    wr(PMC_OFS, M_ED | M_WOL | 32'h10);
    rchk(PMC_OFS, M_RDY | M_ED | M_WOL);
    chk({31'h0, intr}, 32'h0);
    evt(1'h0, 1'h1);
    rchk(PMC_OFS, M_RDY | M_ED | M_WOL | 32'h20);
    soft_reset_bit();
  endtask
  task t_static;
    wr(PMC_OFS, M_OE | M_POL | M_PP | M_ED);
    cyc(3);
    chk({30'h0, pin_oe, lvl}, 32'h2);
    evt(1'h1, 1'h0);
    cyc(PC * 2);
    chk({31'h0, lvl}, 32'h1);
    wr(PMC_OFS, M_OE | M_POL | M_PP);
    cyc(3);
    chk({31'h0, lvl}, 32'h0);
    wr(PMC_OFS, M_OE | M_PP | M_ED);
    cyc(3);
    chk({31'h0, lvl}, 32'h1);
    evt(1'h1, 1'h0);
    chk({31'h0, lvl}, 32'h0);
    wr(PMC_OFS, M_PP | M_ED);
    cyc(3);
    chk({31'h0, pin_oe}, 32'h0);
    wr(PMC_OFS, M_OE | M_PP | M_ED | 32'h10);
    cyc(3);
    chk({30'h0, pin_oe, lvl}, 32'h3);
    soft_reset_bit();
  endtask
  task t_pulse;
    wr(PMC_OFS, M_OE | M_POL | M_PP | M_PUL | M_WOL);
    act_lvl <= 1'h1;
    clr <= 1'h1;
    cyc(1);
    clr <= 1'h0;
    evt(1'h0, 1'h1);
    cyc(PC * 3);
    chk({16'h0000, act_cnt}, PC);
    rchk(PMC_OFS, M_RDY | M_OE | M_POL | M_PP | M_PUL | M_WOL | 32'h20);
    soft_reset_bit();
  endtask
  task t_open;
    wr(PMC_OFS, M_OE | M_POL | M_ED);
    cyc(3);
    chk({30'h0, pin_oe, lvl}, 32'h1);
    evt(1'h1, 1'h0);
    chk({30'h0, pin_oe, lvl}, 32'h2);
    soft_reset_bit();
  endtask
  task t_soft;
    wr(PMC_OFS, M_OE | M_POL | M_PP | M_PUL | M_ED | M_WOL);
    soft_reset_bit();
    rchk(PMC_OFS, M_RDY | M_POL | M_PP);
  endtask
  task t_power;
    wr(PMC_OFS, M_ED);
    evt(1'h1, 1'h0);
    wr(PMC_OFS, M_ED | 32'h1000);
    cyc(4);
    chk({30'h0, pstate, ready}, 32'h2);
    rchk(PMC_OFS, M_ED | 32'h1010);
    wr(PMC_OFS, M_ED | 32'h10);
    wr(BYTE_TEST_OFS, 32'hA5A5_A5A5);
    wait_ready();
    rchk(PMC_OFS, M_RDY | M_ED | 32'h10);
    wr(PMC_OFS, M_ED | 32'h3000);
    rchk(PMC_OFS, M_RDY | M_ED | 32'h10);
    wr(PMC_OFS, M_ED | 32'h2010);
    cyc(4);
    chk({30'h0, pstate}, 32'h2);
    evt(1'h1, 1'h0);
    wait_ready();
    rchk(PMC_OFS, M_RDY | M_ED | 32'h10);
    chk({30'h0, pstate}, 32'h0);
  endtask
  // ==========================================================
  // Main sequence: reset, scenarios, verdict
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'h1;
    clr <= 1'h0;
    t_boot();
    t_codes();
    t_static();
    t_pulse();
    t_open();
    t_soft();
    t_power();
    summarize();
  end
endmodule
